// ==== cpu_decode_pkg.sv ====
// package: constants and types for the instruction class decoder
package cpu_decode_pkg;
  localparam logic [15:0] RESET_PC = 16'h0020;
  localparam logic [7:0] SP_RESET = 8'hFF;
  localparam logic [7:0] DIRECT_PAGE_HI = 8'h00;
  localparam logic [7:0] STACK_PAGE_HI = 8'h00;
  localparam logic [4:0] CCR_RESET = 5'h08;
  localparam int CCR_H = 4;
  localparam int CCR_I = 3;
  localparam int CCR_N = 2;
  localparam int CCR_Z = 1;
  localparam int CCR_C = 0;
  localparam logic [7:0] OP_UNS_MULTIPLY = 8'h42;
  localparam logic [7:0] OP_STOP = 8'h8E;
  localparam logic [7:0] OP_WAIT = 8'h8F;
  localparam logic [7:0] OP_TAX = 8'h97;
  localparam logic [7:0] OP_CLC = 8'h98;
  localparam logic [7:0] OP_SEC = 8'h99;
  localparam logic [7:0] OP_CLI = 8'h9A;
  localparam logic [7:0] OP_SEI = 8'h9B;
  localparam logic [7:0] OP_TXA = 8'h9F;
  localparam logic [3:0] ROW_BRBIT = 4'h0;
  localparam logic [3:0] ROW_BITSET = 4'h1;
  localparam logic [3:0] ROW_REL = 4'h2;
  localparam logic [3:0] ROW_RMW_DIR = 4'h3;
  localparam logic [3:0] ROW_RMW_A = 4'h4;
  localparam logic [3:0] ROW_RMW_X = 4'h5;
  localparam logic [3:0] ROW_CTRL_LO = 4'h8;
  localparam logic [3:0] ROW_CTRL_HI = 4'h9;
  localparam logic [3:0] ROW_IMM = 4'hA;
  localparam logic [3:0] ROW_DIR = 4'hB;
  localparam logic [3:0] FN_STA = 4'h7;
  localparam logic [3:0] FN_ADC = 4'h9;
  localparam logic [3:0] FN_ADD = 4'hB;
  localparam logic [3:0] FN_UNCOND_JUMP = 4'hC;
  localparam logic [3:0] FN_STX = 4'hF;
  localparam logic [3:0] RMW_TEST_NZ = 4'hD;
  typedef enum logic [2:0] {CL_REGMEM, CL_RMW, CL_JUMP, CL_BIT, CL_CTRL} iclass_t;
  typedef enum logic [2:0] {ST_FETCH, ST_OPCODE, ST_BYTE2, ST_BYTE3, ST_DATA, ST_PUSH, ST_HALT} state_t;
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } mem_req_t;
  typedef struct packed {
    state_t st;
    logic [15:0] pc;
    logic [15:0] tgt;
    logic [7:0] sp;
    logic [7:0] a;
    logic [7:0] x;
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] off;
    logic [4:0] ccr;
    mem_req_t mem;
    logic osc_stop;
    logic clk_halt;
    logic irq_en;
    logic irq_meta;
    logic irq_sync;
  } core_state_t;
endpackage

// ==== cpu_instruction_class_decode.sv ====
// cpu core sequencing the five instruction classes
`timescale 1ns/100ps
// Notes on behaviour
// - two-operand register/memory ops take A or X plus one memory byte.
// - read-modify-write reads target, modifies, writes back to same target.
// - bit set and bit clear exist only with direct addressing.
// - test negative or zero reads and evaluates but never writes back.
// - false branch condition leaves program counter on sequential path.
// - bit-test branches are opcode, direct address, signed offset: three bytes.
// - tested bit number and polarity come from the opcode itself.
// - taken bit-test branch goes to next address plus sign-extended offset.
// - bit-test branches copy tested bit into carry, taken or not.
// - bit-test branches reach any bit in the lowest 256 addresses.
// - bit set and clear reach any writable bit in lowest 256 bytes.
// - jump and jump-to-subroutine use no CPU register operand.
// - two branches test the interrupt pin level, high and low.
// - stop halts the oscillator and enables the interrupt pin.
// - wait halts the CPU clock, enables interrupts, oscillator keeps running.
// - multiply A by X, high byte to X, low byte to A.
// - direct addressing is two bytes, high address byte forced to zero.
module cpu_instruction_class_decode #(
  parameter logic [15:0] RESET_PC = cpu_decode_pkg::RESET_PC
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic IRQ_N_I,
  input wire logic [7:0] MEM_RDATA_I,
  output logic [15:0] MEM_ADDR_O,
  output logic MEM_RD_O,
  output logic MEM_WR_O,
  output logic [7:0] MEM_WDATA_O,
  output logic [7:0] ACC_O,
  output logic [7:0] IDX_O,
  output logic [4:0] CCR_O,
  output logic [15:0] PC_O,
  output logic OSC_STOP_O,
  output logic CPU_CLK_HALT_O,
  output logic IRQ_PIN_EN_O
);
  cpu_decode_pkg::core_state_t s_reg, s_next;
  cpu_decode_pkg::iclass_t cls_w;
  logic [7:0] op_w, rmw_in, rel_off;
  logic [3:0] lo, row;
  logic [11:0] alu_r;
  logic [10:0] rmw_r;
  logic [15:0] rel_tgt, dir_w, prod;
  logic [4:0] half;
  logic br_cond, bit_val, bit_taken, do_alu, do_rmw;

  function automatic cpu_decode_pkg::iclass_t classify(input logic [7:0] o);
    if (o[7:4] == cpu_decode_pkg::ROW_BRBIT || o[7:4] == cpu_decode_pkg::ROW_BITSET) classify = cpu_decode_pkg::CL_BIT;
    else if (o[7:4] == cpu_decode_pkg::ROW_REL) classify = cpu_decode_pkg::CL_JUMP;
    else if (o == cpu_decode_pkg::OP_UNS_MULTIPLY) classify = cpu_decode_pkg::CL_REGMEM;
    else if (o[7:4] < cpu_decode_pkg::ROW_CTRL_LO) classify = cpu_decode_pkg::CL_RMW;
    else if (o[7:4] <= cpu_decode_pkg::ROW_CTRL_HI) classify = cpu_decode_pkg::CL_CTRL;
    else if (o[3:1] == cpu_decode_pkg::FN_UNCOND_JUMP[3:1]) classify = cpu_decode_pkg::CL_JUMP;
    else classify = cpu_decode_pkg::CL_REGMEM;
  endfunction

  // returns {carry valid, carry, dest 1=A 2=X, result}
  function automatic logic [11:0] alu_f(input logic [3:0] f, input logic [7:0] a, x, m, input logic c);
    logic [8:0] s;
    logic [1:0] d;
    logic cv;
    logic [7:0] r;
    s = 9'h000;
    d = 2'h0;
    cv = 1'b0;
    r = a;
    case (f)
      4'h0: begin s = {1'b0, a} - {1'b0, m}; cv = 1'b1; d = 2'h1; end
      4'h1: begin s = {1'b0, a} - {1'b0, m}; cv = 1'b1; end
      4'h2: begin s = {1'b0, a} - {1'b0, m} - {8'h00, c}; cv = 1'b1; d = 2'h1; end
      4'h3: begin s = {1'b0, x} - {1'b0, m}; cv = 1'b1; end
      4'h4: begin r = a & m; d = 2'h1; end
      4'h5: r = a & m;
      4'h6: begin r = m; d = 2'h1; end
      4'h8: begin r = a ^ m; d = 2'h1; end
      4'h9: begin s = {1'b0, a} + {1'b0, m} + {8'h00, c}; cv = 1'b1; d = 2'h1; end
      4'hA: begin r = a | m; d = 2'h1; end
      4'hB: begin s = {1'b0, a} + {1'b0, m}; cv = 1'b1; d = 2'h1; end
      4'hE: begin r = m; d = 2'h2; end
      4'hF: r = x;
      default: r = a;
    endcase
    if (cv) r = s[7:0];
    alu_f = {cv, s[8], d, r};
  endfunction

  // returns {write back, carry valid, carry, result}
  function automatic logic [10:0] rmw_f(input logic [3:0] f, input logic [7:0] v, input logic c);
    logic [7:0] r;
    logic w, cv, co;
    r = v;
    w = 1'b1;
    cv = 1'b1;
    co = c;
    case (f)
      4'h0: begin r = 8'h00 - v; co = (v != 8'h00); end
      4'h3: begin r = ~v; co = 1'b1; end
      4'h4: begin r = {1'b0, v[7:1]}; co = v[0]; end
      4'h6: begin r = {c, v[7:1]}; co = v[0]; end
      4'h7: begin r = {v[7], v[7:1]}; co = v[0]; end
      4'h8: begin r = {v[6:0], 1'b0}; co = v[7]; end
      4'h9: begin r = {v[6:0], c}; co = v[7]; end
      4'hA: begin r = v - 8'h01; cv = 1'b0; end
      4'hC: begin r = v + 8'h01; cv = 1'b0; end
      4'hF: begin r = 8'h00; cv = 1'b0; end
      default: begin w = 1'b0; cv = 1'b0; end // test and unused codes: no write
    endcase
    rmw_f = {w, cv, co, r};
  endfunction

  always_comb begin
    op_w = (s_reg.st == cpu_decode_pkg::ST_OPCODE) ? MEM_RDATA_I : s_reg.op;
    cls_w = classify(op_w);
    lo = op_w[3:0];
    row = op_w[7:4];
    dir_w = {cpu_decode_pkg::DIRECT_PAGE_HI, MEM_RDATA_I};
    rel_off = (s_reg.st == cpu_decode_pkg::ST_BYTE2) ? MEM_RDATA_I : s_reg.off;
    rel_tgt = s_reg.pc + {{8{rel_off[7]}}, rel_off};
    prod = {8'h00, s_reg.a} * {8'h00, s_reg.x};
    alu_r = alu_f(lo, s_reg.a, s_reg.x, MEM_RDATA_I, s_reg.ccr[cpu_decode_pkg::CCR_C]);
    half = {1'b0, s_reg.a[3:0]} + {1'b0, MEM_RDATA_I[3:0]}
      + {4'h0, s_reg.ccr[cpu_decode_pkg::CCR_C] & (lo == cpu_decode_pkg::FN_ADC)};
    rmw_in = (s_reg.st != cpu_decode_pkg::ST_OPCODE) ? MEM_RDATA_I :
      ((row == cpu_decode_pkg::ROW_RMW_X) ? s_reg.x : s_reg.a);
    rmw_r = rmw_f(lo, rmw_in, s_reg.ccr[cpu_decode_pkg::CCR_C]);
    bit_val = MEM_RDATA_I[s_reg.op[3:1]];
    bit_taken = bit_val ^ s_reg.op[0];
    case (op_w[3:1])
      3'h0: br_cond = 1'b1;
      3'h1: br_cond = ~(s_reg.ccr[cpu_decode_pkg::CCR_C] | s_reg.ccr[cpu_decode_pkg::CCR_Z]);
      3'h2: br_cond = ~s_reg.ccr[cpu_decode_pkg::CCR_C];
      3'h3: br_cond = ~s_reg.ccr[cpu_decode_pkg::CCR_Z];
      3'h4: br_cond = ~s_reg.ccr[cpu_decode_pkg::CCR_H];
      3'h5: br_cond = ~s_reg.ccr[cpu_decode_pkg::CCR_N];
      3'h6: br_cond = ~s_reg.ccr[cpu_decode_pkg::CCR_I];
      3'h7: br_cond = ~s_reg.irq_sync;
      default: br_cond = 1'b0;
    endcase
    br_cond = br_cond ^ op_w[0];
  end

  always_comb begin
    s_next = s_reg;
    s_next.irq_meta = IRQ_N_I;
    s_next.irq_sync = s_reg.irq_meta;
    s_next.mem.rd = 1'b0;
    s_next.mem.wr = 1'b0;
    do_alu = 1'b0;
    do_rmw = 1'b0;
    case (s_reg.st)
      cpu_decode_pkg::ST_FETCH: begin
        s_next.mem.addr = s_reg.pc;
        s_next.mem.rd = 1'b1;
        s_next.pc = s_reg.pc + 16'h0001;
        s_next.st = cpu_decode_pkg::ST_OPCODE;
      end
      cpu_decode_pkg::ST_OPCODE: begin
        s_next.op = MEM_RDATA_I;
        s_next.st = cpu_decode_pkg::ST_FETCH;
        if (row <= cpu_decode_pkg::ROW_RMW_DIR || row == cpu_decode_pkg::ROW_IMM || row == cpu_decode_pkg::ROW_DIR) begin
          s_next.mem.addr = s_reg.pc;
          s_next.mem.rd = 1'b1;
          s_next.pc = s_reg.pc + 16'h0001;
          s_next.st = cpu_decode_pkg::ST_BYTE2;
        end else if (op_w == cpu_decode_pkg::OP_UNS_MULTIPLY) begin
          {s_next.x, s_next.a} = prod;
          s_next.ccr[cpu_decode_pkg::CCR_C] = 1'b0;
          s_next.ccr[cpu_decode_pkg::CCR_H] = 1'b0;
        end else if (cls_w == cpu_decode_pkg::CL_RMW) begin
          do_rmw = 1'b1;
        end else begin
          case (op_w)
            cpu_decode_pkg::OP_CLC: s_next.ccr[cpu_decode_pkg::CCR_C] = 1'b0;
            cpu_decode_pkg::OP_SEC: s_next.ccr[cpu_decode_pkg::CCR_C] = 1'b1;
            cpu_decode_pkg::OP_CLI: s_next.ccr[cpu_decode_pkg::CCR_I] = 1'b0;
            cpu_decode_pkg::OP_SEI: s_next.ccr[cpu_decode_pkg::CCR_I] = 1'b1;
            cpu_decode_pkg::OP_TAX: s_next.x = s_reg.a;
            cpu_decode_pkg::OP_TXA: s_next.a = s_reg.x;
            cpu_decode_pkg::OP_STOP: begin
              s_next.osc_stop = 1'b1;
              s_next.irq_en = 1'b1;
              s_next.ccr[cpu_decode_pkg::CCR_I] = 1'b0;
              s_next.st = cpu_decode_pkg::ST_HALT;
            end
            cpu_decode_pkg::OP_WAIT: begin
              s_next.clk_halt = 1'b1;
              s_next.ccr[cpu_decode_pkg::CCR_I] = 1'b0;
              s_next.st = cpu_decode_pkg::ST_HALT;
            end
            default: s_next.st = cpu_decode_pkg::ST_FETCH; // unsupported opcodes run as one-byte no-ops
          endcase
        end
      end
      cpu_decode_pkg::ST_BYTE2: begin
        s_next.b2 = MEM_RDATA_I;
        s_next.st = cpu_decode_pkg::ST_FETCH;
        s_next.mem.addr = dir_w;
        if (row == cpu_decode_pkg::ROW_BRBIT) begin
          s_next.mem.addr = s_reg.pc;
          s_next.mem.rd = 1'b1;
          s_next.pc = s_reg.pc + 16'h0001;
          s_next.st = cpu_decode_pkg::ST_BYTE3;
        end else if (row == cpu_decode_pkg::ROW_REL) begin
          if (br_cond) s_next.pc = rel_tgt;
        end else if (cls_w == cpu_decode_pkg::CL_JUMP) begin
          s_next.tgt = (row == cpu_decode_pkg::ROW_IMM) ? rel_tgt : dir_w;
          if (lo == cpu_decode_pkg::FN_UNCOND_JUMP) begin
            s_next.pc = s_next.tgt;
          end else begin
            s_next.mem.addr = {cpu_decode_pkg::STACK_PAGE_HI, s_reg.sp};
            s_next.mem.wr = 1'b1;
            s_next.mem.wdata = s_reg.pc[7:0];
            s_next.sp = s_reg.sp - 8'h01;
            s_next.st = cpu_decode_pkg::ST_PUSH;
          end
        end else if (row == cpu_decode_pkg::ROW_IMM) begin
          do_alu = 1'b1;
        end else if (row == cpu_decode_pkg::ROW_DIR && (lo == cpu_decode_pkg::FN_STA || lo == cpu_decode_pkg::FN_STX)) begin
          do_alu = 1'b1;
          s_next.mem.wr = 1'b1;
          s_next.mem.wdata = alu_r[7:0];
        end else begin
          s_next.mem.rd = 1'b1;
          s_next.st = cpu_decode_pkg::ST_DATA;
        end
      end
      cpu_decode_pkg::ST_BYTE3: begin
        s_next.off = MEM_RDATA_I;
        s_next.mem.addr = {cpu_decode_pkg::DIRECT_PAGE_HI, s_reg.b2};
        s_next.mem.rd = 1'b1;
        s_next.st = cpu_decode_pkg::ST_DATA;
      end
      cpu_decode_pkg::ST_DATA: begin
        s_next.st = cpu_decode_pkg::ST_FETCH;
        if (row == cpu_decode_pkg::ROW_BRBIT) begin
          s_next.ccr[cpu_decode_pkg::CCR_C] = bit_val;
          if (bit_taken) s_next.pc = rel_tgt;
        end else if (row == cpu_decode_pkg::ROW_BITSET) begin
          s_next.mem.wr = 1'b1;
          s_next.mem.wdata = MEM_RDATA_I;
          s_next.mem.wdata[s_reg.op[3:1]] = ~s_reg.op[0];
        end else if (cls_w == cpu_decode_pkg::CL_RMW) begin
          do_rmw = 1'b1;
        end else begin
          do_alu = 1'b1;
        end
      end
      cpu_decode_pkg::ST_PUSH: begin
        s_next.mem.addr = {cpu_decode_pkg::STACK_PAGE_HI, s_reg.sp};
        s_next.mem.wr = 1'b1;
        s_next.mem.wdata = s_reg.pc[15:8];
        s_next.sp = s_reg.sp - 8'h01;
        s_next.pc = s_reg.tgt;
        s_next.st = cpu_decode_pkg::ST_FETCH;
      end
      cpu_decode_pkg::ST_HALT: begin
        // only a low interrupt pin wakes; other sources are outside this core
        if (!s_reg.irq_sync) begin
          s_next.osc_stop = 1'b0;
          s_next.clk_halt = 1'b0;
          s_next.irq_en = 1'b0;
          s_next.st = cpu_decode_pkg::ST_FETCH;
        end
      end
      default: s_next.st = cpu_decode_pkg::ST_FETCH;
    endcase
    if (do_alu) begin
      if (alu_r[9:8] == 2'h1) s_next.a = alu_r[7:0];
      if (alu_r[9:8] == 2'h2) s_next.x = alu_r[7:0];
      s_next.ccr[cpu_decode_pkg::CCR_N] = alu_r[7];
      s_next.ccr[cpu_decode_pkg::CCR_Z] = (alu_r[7:0] == 8'h00);
      if (alu_r[11]) s_next.ccr[cpu_decode_pkg::CCR_C] = alu_r[10];
      if (lo == cpu_decode_pkg::FN_ADC || lo == cpu_decode_pkg::FN_ADD) s_next.ccr[cpu_decode_pkg::CCR_H] = half[4];
    end
    if (do_rmw) begin
      s_next.ccr[cpu_decode_pkg::CCR_N] = rmw_r[7];
      s_next.ccr[cpu_decode_pkg::CCR_Z] = (rmw_r[7:0] == 8'h00);
      if (rmw_r[9]) s_next.ccr[cpu_decode_pkg::CCR_C] = rmw_r[8];
      if (rmw_r[10] && s_reg.st == cpu_decode_pkg::ST_OPCODE) begin
        if (row == cpu_decode_pkg::ROW_RMW_X) s_next.x = rmw_r[7:0];
        else s_next.a = rmw_r[7:0];
      end
      if (rmw_r[10] && s_reg.st == cpu_decode_pkg::ST_DATA) begin
        s_next.mem.wr = 1'b1;
        s_next.mem.wdata = rmw_r[7:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_reg <= '0;
      s_reg.pc <= RESET_PC;
      s_reg.sp <= cpu_decode_pkg::SP_RESET;
      s_reg.ccr <= cpu_decode_pkg::CCR_RESET;
      s_reg.irq_meta <= 1'b1;
      s_reg.irq_sync <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign MEM_ADDR_O = s_reg.mem.addr;
  assign MEM_RD_O = s_reg.mem.rd;
  assign MEM_WR_O = s_reg.mem.wr;
  assign MEM_WDATA_O = s_reg.mem.wdata;
  assign ACC_O = s_reg.a;
  assign IDX_O = s_reg.x;
  assign CCR_O = s_reg.ccr;
  assign PC_O = s_reg.pc;
  assign OSC_STOP_O = s_reg.osc_stop;
  assign CPU_CLK_HALT_O = s_reg.clk_halt;
  assign IRQ_PIN_EN_O = s_reg.irq_en;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence rmw_read_s;
    s_reg.st == cpu_decode_pkg::ST_DATA && cls_w == cpu_decode_pkg::CL_RMW;
  endsequence
  sequence bitbr_steps_s;
    ##1 s_reg.st == cpu_decode_pkg::ST_BYTE2 ##1 s_reg.st == cpu_decode_pkg::ST_BYTE3
      ##1 s_reg.st == cpu_decode_pkg::ST_DATA;
  endsequence
  rmw_writeback_a: assert property (rmw_read_s ##0 rmw_r[10] |=> MEM_WR_O && MEM_ADDR_O == $past(MEM_ADDR_O)
    && MEM_WDATA_O == $past(rmw_r[7:0])) else $error("read-modify-write result not stored to its source");
  test_no_write_a: assert property (rmw_read_s ##0 lo == cpu_decode_pkg::RMW_TEST_NZ |=> !MEM_WR_O)
    else $error("test instruction wrote memory");
  bit_carry_a: assert property (s_reg.st == cpu_decode_pkg::ST_DATA && row == cpu_decode_pkg::ROW_BRBIT
    |=> CCR_O[cpu_decode_pkg::CCR_C] == $past(bit_val)) else $error("tested bit not copied to carry");
  bit_target_a: assert property (s_reg.st == cpu_decode_pkg::ST_DATA && row == cpu_decode_pkg::ROW_BRBIT
    |=> PC_O == ($past(bit_taken) ? $past(rel_tgt) : $past(PC_O))) else $error("bit branch target wrong");
  bit_branch_len_a: assert property (s_reg.st == cpu_decode_pkg::ST_OPCODE && MEM_RDATA_I[7:4] == 4'h0
    |-> bitbr_steps_s ##0 PC_O == $past(PC_O, 3) + 16'h0002) else $error("bit branch not three bytes");
  branch_hold_a: assert property (s_reg.st == cpu_decode_pkg::ST_BYTE2 && row == cpu_decode_pkg::ROW_REL
    && !br_cond |=> PC_O == $past(PC_O)) else $error("untaken branch moved program counter");
  irq_pin_branch_a: assert property (s_reg.st == cpu_decode_pkg::ST_BYTE2 && s_reg.op[7:1] == 7'h17
    |=> PC_O == (($past(s_reg.op[0]) == $past(s_reg.irq_sync)) ? $past(rel_tgt) : $past(PC_O)))
    else $error("pin level branch wrong");
  bitset_page_a: assert property (s_reg.st == cpu_decode_pkg::ST_DATA && row == cpu_decode_pkg::ROW_BITSET
    |=> MEM_WR_O && MEM_ADDR_O[15:8] == cpu_decode_pkg::DIRECT_PAGE_HI) else $error("bit set/clear not direct");
  stop_mode_a: assert property (s_reg.st == cpu_decode_pkg::ST_OPCODE && op_w == cpu_decode_pkg::OP_STOP
    |=> OSC_STOP_O && IRQ_PIN_EN_O && s_reg.st == cpu_decode_pkg::ST_HALT) else $error("stop did not halt");
  wait_mode_a: assert property (s_reg.st == cpu_decode_pkg::ST_OPCODE && op_w == cpu_decode_pkg::OP_WAIT
    |=> CPU_CLK_HALT_O && !OSC_STOP_O && !CCR_O[cpu_decode_pkg::CCR_I]) else $error("wait state wrong");
  product_place_a: assert property (s_reg.st == cpu_decode_pkg::ST_OPCODE && op_w == cpu_decode_pkg::OP_UNS_MULTIPLY
    |=> {IDX_O, ACC_O} == $past(prod)) else $error("multiply result misplaced");
  jump_regs_a: assert property (s_reg.st == cpu_decode_pkg::ST_BYTE2 && cls_w == cpu_decode_pkg::CL_JUMP
    |=> ACC_O == $past(ACC_O) && IDX_O == $past(IDX_O)) else $error("jump altered a register");
endmodule // cpu_instruction_class_decode

// ==== cpu_mem_model.sv ====
// behavioural memory standing on the core's memory port
`timescale 1ns/100ps
module cpu_mem_model (
  input wire logic clk_i,
  input wire logic [15:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:255];
  logic [7:0] last_reg = 8'h5A;
  // only the low page exists, high address byte ignored
  // no write-only locations, so a read before write-back is always meaningful
  always @(posedge clk_i) begin
    if (wr_i) begin
      mem[addr_i[7:0]] <= wdata_i;
    end
    if (rd_i) begin
      last_reg <= rdata_o;
    end
  end
  // idle bus shows the inverse of the last byte so a late sample is caught
  assign rdata_o = rd_i ? mem[addr_i[7:0]] : ~last_reg;
endmodule // cpu_mem_model

// ==== tb_top.sv ====
// self-checking bench running a short program through the core
`timescale 1ns/100ps
module tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic irq_n = 1'b1;
  logic [7:0] rdata;
  logic [15:0] mem_addr;
  logic mem_rd;
  logic mem_wr;
  logic [7:0] wdata;
  logic [7:0] acc;
  logic [7:0] idx;
  logic [4:0] ccr;
  logic [15:0] pc;
  logic osc_stop;
  logic cpu_halt;
  logic irq_en;
  logic [2:0] stat;
  int err_total = 0;
  int n_compared = 0;
  int wr_count = 0;
  logic [15:0] lfsr = 16'hC4DC;
  assign stat = {osc_stop, cpu_halt, irq_en};
  always #4 core_clk = ~core_clk;
  cpu_instruction_class_decode cpu_instruction_class_decode_inst (.CORE_CLK_I(core_clk), .RST_N_I(rst_n),
    .IRQ_N_I(irq_n), .MEM_RDATA_I(rdata), .MEM_ADDR_O(mem_addr), .MEM_RD_O(mem_rd), .MEM_WR_O(mem_wr),
    .MEM_WDATA_O(wdata), .ACC_O(acc), .IDX_O(idx), .CCR_O(ccr), .PC_O(pc), .OSC_STOP_O(osc_stop),
    .CPU_CLK_HALT_O(cpu_halt), .IRQ_PIN_EN_O(irq_en));
  cpu_mem_model cpu_mem_model_inst (.clk_i(core_clk), .addr_i(mem_addr), .rd_i(mem_rd), .wr_i(mem_wr),
    .wdata_i(wdata), .rdata_o(rdata));
  always @(posedge core_clk) begin
    if (mem_wr === 1'b1) begin
      wr_count <= wr_count + 1;
    end
  end
  function automatic logic [15:0] lfsr_step(input logic [15:0] v);
    return {1'b0, v[15:1]} ^ (v[0] ? 16'hB400 : 16'h0000);
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_fetch(input logic [15:0] a);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (!(mem_rd === 1'b1 && mem_addr === a) && n < 400);
    check(mem_addr, a);
  endtask
  task automatic wait_st(input logic [2:0] mask, input logic [2:0] v);
    int n;
    n = 0;
    while ((stat & mask) !== v && n < 50) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check({13'h0, stat & mask}, {13'h0, v});
  endtask
  task automatic end_of_test();
    if (err_total == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    // a full pass takes under a hundred cycles per seed
    repeat (20000) @(posedge core_clk);
    err_total++;
    end_of_test();
  end
  initial begin
    logic [7:0] r1;
    logic [7:0] r2;
    logic [7:0] r3;
    logic irq_lo;
    logic [15:0] prod;
    logic [7:0] prog [31];
    for (int it = 0; it < 5; it++) begin
      @(posedge core_clk);
      #1;
      rst_n = 1'b0;
      lfsr = lfsr_step(lfsr);
      r1 = lfsr[7:0];
      lfsr = lfsr_step(lfsr);
      r2 = (it == 0) ? 8'hFF : lfsr[7:0];
      lfsr = lfsr_step(lfsr);
      r3 = lfsr[7:0];
      irq_lo = lfsr[9];
      prod = r1 * r2;
      irq_n = ~irq_lo;
      // program: loads, multiply, store, rmw, bit ops, bit branches, pin branches, jump
      prog = '{8'hA6, r1, 8'hAE, r2, 8'h42, 8'hB7, 8'h80, 8'h3C, 8'h80, 8'h3D, 8'h80, 8'h16, 8'h81, 8'h11,
        8'h81, 8'h00, 8'h81, 8'h02, 8'h06, 8'h81, 8'h7F, 8'h9D, 8'h9D, 8'h2E, 8'h02, 8'h2F, 8'h02, 8'h9D,
        8'h9D, 8'hBC, 8'h50};
      for (int k = 0; k < 256; k++) cpu_mem_model_inst.mem[k] = 8'h9D;
      for (int k = 0; k < 31; k++) cpu_mem_model_inst.mem[8'h20 + k] = prog[k];
      cpu_mem_model_inst.mem[8'hB4] = 8'h01;
      cpu_mem_model_inst.mem[8'hB5] = 8'h81;
      cpu_mem_model_inst.mem[8'hB6] = 8'h80;
      cpu_mem_model_inst.mem[8'h50] = 8'h8F;
      cpu_mem_model_inst.mem[8'h51] = 8'h8E;
      cpu_mem_model_inst.mem[8'h52] = 8'h20;
      cpu_mem_model_inst.mem[8'h53] = 8'hFE;
      cpu_mem_model_inst.mem[8'h81] = r3;
      repeat (12) @(posedge core_clk);
      #1;
      wr_count = 0;
      rst_n = 1'b1;
      wait_fetch(16'h0024);
      check({idx, acc}, {r2, r1});
      wait_fetch(16'h0025);
      check({idx, acc}, prod);
      wait_fetch(16'h0027);
      check({8'h00, cpu_mem_model_inst.mem[8'h80]}, {8'h00, prod[7:0]});
      wait_fetch(16'h0029);
      check({8'h00, cpu_mem_model_inst.mem[8'h80]}, {8'h00, prod[7:0] + 8'h01});
      wait_fetch(16'h002B);
      check(wr_count[15:0], 16'h0002);
      check({ccr[cpu_decode_pkg::CCR_N], ccr[cpu_decode_pkg::CCR_Z]},
        {prod[7:0] + 8'h01 >= 8'h80, prod[7:0] == 8'hFF});
      wait_fetch(16'h002F);
      check({8'h00, cpu_mem_model_inst.mem[8'h81]}, {8'h00, (r3 | 8'h08) & 8'hFE});
      wait_fetch(16'h0032);
      check(ccr[cpu_decode_pkg::CCR_C], 1'b0);
      wait_fetch(16'h00B4);
      check(ccr[cpu_decode_pkg::CCR_C], 1'b1);
      wait_fetch(16'h0037);
      check(ccr[cpu_decode_pkg::CCR_C], 1'b0);
      wait_fetch(16'h0038);
      wait_fetch(irq_lo ? 16'h003B : 16'h0039);
      irq_n = 1'b1;
      wait_fetch(16'h003D);
      wait_fetch(16'h0050);
      check({idx, acc}, prod);
      wait_st(3'b010, 3'b010);
      check({11'h0, osc_stop, ccr}, {11'h0, 1'b0, ccr & ~(5'h01 << cpu_decode_pkg::CCR_I)});
      irq_n = 1'b0;
      wait_st(3'b010, 3'b000);
      irq_n = 1'b1;
      wait_st(3'b111, 3'b101);
      check({15'h0, ccr[cpu_decode_pkg::CCR_I]}, 16'h0000);
      irq_n = 1'b0;
      wait_st(3'b100, 3'b000);
      irq_n = 1'b1;
      wait_fetch(16'h0052);
    end
    end_of_test();
  end
endmodule // tb_top
